//--- design/eas_pkg.sv
// Package for the early-acknowledge bus slave: constants and carrier types
// Notes on behaviour
// - Card suppresses early acknowledge while it cannot serve data, e.g. refresh.
// - Without any enable strobe, every cycle still completes via normal acknowledge.
// - During DMA cycles memory uses the strobe, I/O cards ignore it.
// - Acknowledge must be valid one 125 ns period after enable strobe asserts.
// - Enable strobe to acknowledge within 54 ns; keep internal delay minimal.
// - Early-acked read data valid within 303 ns of address strobe falling.
// - Write data captured within 345 ns of address, 220 ns of data strobes.
package eas_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int ACK_MAX_NS       = 54;
  localparam int RD_DATA_MAX_NS   = 303;
  localparam int WR_AS_MAX_NS     = 345;
  localparam int WR_DS_MAX_NS     = 220;
  // Longest times round down
  localparam int ACK_MAX_CYC      = (ACK_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int RD_DATA_MAX_CYC  = (RD_DATA_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int WR_AS_MAX_CYC    = (WR_AS_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int WR_DS_MAX_CYC    = (WR_DS_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [5:0] CNT_RST  = 6'h00;
  localparam logic [5:0] CNT_MAX  = 6'h3F;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    EAS_IDLE = 2'b00,
    EAS_BUSY = 2'b01,
    EAS_ACK  = 2'b11
  } eas_state_t;

  typedef struct packed {
    logic bus_address_strobe_b;
    logic upper_byte_strobe_b;
    logic lower_byte_strobe_b;
    logic early_ack_enable_b;
    logic write_b;
    logic dma_cycle;
  } eas_bus_in_t;

  typedef struct packed {
    eas_state_t state;
    logic [5:0] cnt;
    logic       ack;
    logic       early;
    logic       req;
    logic       wr;
    logic       oe_b;
    logic [15:0] rdata;
  } eas_state_s_t;

endpackage

//--- design/eas_slave.sv
// Bus slave that answers with an early transfer acknowledge from the enable strobe
module eas_slave
  import eas_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Bus side, active-low strobes
  input  wire eas_bus_in_t bus_in,
  input  wire logic [15:0] bus_data_in,
  output logic [15:0]      bus_data_out,
  output logic             bus_data_oe_b,
  output logic             transfer_acknowledge_b_out,
  output logic             transfer_acknowledge_oe_b,
  // Card side
  input  wire logic        card_select,
  input  wire logic        card_is_memory,
  input  wire logic        refresh_busy,
  output logic             mem_req,
  output logic             mem_wr,
  input  wire logic        mem_done,
  input  wire logic [15:0] mem_rdata,
  output logic             early_used
);

  // ****************************************
  // State
  // ****************************************
  eas_state_s_t s_q;
  eas_state_s_t s_d;
  logic as_on;
  logic ds_on;
  logic en_on;
  logic early_ok;

  assign as_on = !bus_in.bus_address_strobe_b;
  assign ds_on = !bus_in.upper_byte_strobe_b || !bus_in.lower_byte_strobe_b;
  assign en_on = !bus_in.early_ack_enable_b;
  // Early path allowed only if selected, not refreshing, and memory for DMA
  assign early_ok = card_select && !refresh_busy
                    && (!bus_in.dma_cycle || card_is_memory);

  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    if (!as_on) begin
      // Release state, acknowledge, early flag, data drive and counter as soon as the address strobe rises
      s_d.state = EAS_IDLE;
      s_d.ack   = 1'b0;
      s_d.early = 1'b0;
      s_d.oe_b  = 1'b1;
      s_d.cnt   = CNT_RST;
    end else begin
      if (s_q.cnt != CNT_MAX) begin
        s_d.cnt = s_q.cnt + 6'h01;
      end
      unique case (s_q.state)
        EAS_IDLE: begin
          // Writes wait for the byte strobes so write data is stable
          if (card_select && (bus_in.write_b || ds_on)) begin
            s_d.state = EAS_BUSY;
            s_d.req   = 1'b1;
            s_d.wr    = !bus_in.write_b;
          end
        end
        EAS_BUSY: begin
          if (mem_done) begin
            s_d.rdata = mem_rdata;
            s_d.oe_b  = !bus_in.write_b ? 1'b1 : 1'b0;
            s_d.ack   = 1'b1;
            s_d.state = EAS_ACK;
          end
          // One register stage from the strobe keeps the delay at one cycle
          if (en_on && early_ok) begin
            s_d.ack   = 1'b1;
            s_d.early = 1'b1;
          end
        end
        EAS_ACK: begin
          if (mem_done && s_q.oe_b && bus_in.write_b) begin
            s_d.rdata = mem_rdata;
            s_d.oe_b  = 1'b0;
          end
        end
        default: s_d.state = EAS_IDLE;
      endcase
      // Early-acked read not yet served: drive data when it lands
      if (s_q.state == EAS_BUSY && mem_done && bus_in.write_b) begin
        s_d.oe_b = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{state: EAS_IDLE, cnt: CNT_RST, ack: 1'b0, early: 1'b0, req: 1'b0,
               wr: 1'b0, oe_b: 1'b1, rdata: 16'h0000};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign bus_data_out               = s_q.rdata;
  assign bus_data_oe_b              = s_q.oe_b;
  assign transfer_acknowledge_b_out = 1'b0;
  assign transfer_acknowledge_oe_b  = !s_q.ack;
  assign mem_req                    = s_q.req;
  assign mem_wr                     = s_q.wr;
  assign early_used                 = s_q.early;

  // ****************************************
  // Checks
  // ****************************************
  AST_RELEASE_ON_AS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && !as_on |=> transfer_acknowledge_oe_b)
    else $error("acknowledge held after address strobe rose");
  AST_NO_EARLY_REFRESH: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && refresh_busy && !s_q.early && !mem_done |=> !s_q.early)
    else $error("early acknowledge during refresh");
  AST_EARLY_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && s_q.state == EAS_BUSY && en_on && early_ok |=> !transfer_acknowledge_oe_b)
    else $error("early acknowledge late");
  AST_FALLBACK: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && s_q.state == EAS_BUSY && mem_done |=> s_q.ack)
    else $error("normal acknowledge missing");
  AST_DMA_IO: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && bus_in.dma_cycle && !card_is_memory && !s_q.early && !mem_done |=> !s_q.early)
    else $error("I/O card used enable strobe in DMA");
  AST_SELECT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && s_q.state == EAS_IDLE && !card_select |=> s_q.state == EAS_IDLE)
    else $error("unselected card started cycle");
  AST_RD_DATA: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && s_q.state != EAS_IDLE && bus_in.write_b && mem_done |=> !bus_data_oe_b)
    else $error("read data not driven");
  AST_WR_NO_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !bus_in.write_b && $past(!bus_in.write_b) && s_q.state == EAS_BUSY |-> bus_data_oe_b)
    else $error("slave drove data on write");

  // ****************************************
  // Budget checks
  // ****************************************
  // Counter reaches the budget whenever the address strobe stays low that long; flags read data not yet driven
  AST_RD_DATA_DUE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && s_q.early && !s_q.wr && s_q.cnt == 6'(RD_DATA_MAX_CYC)
    |-> !bus_data_oe_b)
    else $error("early-acked read data late");

  AST_WR_CAPTURE_AS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && !bus_in.write_b && card_select && s_q.cnt == 6'(WR_AS_MAX_CYC)
    |-> s_q.state != EAS_IDLE)
    else $error("write not captured in time");

  AST_WR_WAITS_DS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && s_q.state == EAS_IDLE && !bus_in.write_b && !ds_on |=> !mem_req)
    else $error("write started before byte strobes");

  AST_WR_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && mem_req |-> mem_wr == !bus_in.write_b)
    else $error("access direction wrong");

  // ****************************************
  // Handshake checks
  // ****************************************
  AST_ACK_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && !transfer_acknowledge_oe_b |=> !transfer_acknowledge_oe_b)
    else $error("acknowledge dropped while strobe low");

  AST_DATA_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && bus_in.write_b && !bus_data_oe_b |=> !bus_data_oe_b)
    else $error("read data dropped while strobe low");

  AST_RD_DATA_VALUE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && s_q.state == EAS_BUSY && bus_in.write_b && mem_done
    |=> bus_data_out == $past(mem_rdata))
    else $error("read data not taken from memory");

  AST_EARLY_NEEDS_SEL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && !card_select && !s_q.early |=> !s_q.early)
    else $error("early acknowledge without select");

  AST_EARLY_NEEDS_EN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && !en_on && !s_q.early |=> !s_q.early)
    else $error("early acknowledge without enable strobe");

  AST_EARLY_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && !as_on |=> !early_used)
    else $error("early flag held after strobe rose");

  AST_NO_REQ_UNSEL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && !card_select |=> !mem_req)
    else $error("access started while unselected");

  AST_REQ_ON_START: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && s_q.state == EAS_IDLE && card_select && bus_in.write_b
    |=> mem_req && s_q.state == EAS_BUSY)
    else $error("selected read not started");

  // Refused early path must still end in the normal answer
  AST_REFRESH_NORMAL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && s_q.state == EAS_BUSY && refresh_busy && mem_done
    |=> !transfer_acknowledge_oe_b)
    else $error("no acknowledge after refresh-blocked cycle");

  AST_IO_DMA_NORMAL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && s_q.state == EAS_BUSY && bus_in.dma_cycle && !card_is_memory
    && mem_done |=> !transfer_acknowledge_oe_b)
    else $error("no acknowledge for I/O card in DMA");

  AST_ACK_IN_ACK_STATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && as_on && s_q.state == EAS_ACK |-> !transfer_acknowledge_oe_b)
    else $error("acknowledge missing in answer state");

endmodule

//--- verif/eas_master.sv
// Behavioural bus master model for the early-acknowledge slave
module eas_master
  import eas_pkg::*;
(
  // Clock and answers
  input  wire logic        clk_sys,
  input  wire logic        ack_b,
  input  wire logic        data_oe_b,
  input  wire logic [15:0] data_in,
  input  wire logic        early_in,
  // Strobes and write data
  output eas_bus_in_t      bus,
  output logic [15:0]      wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int          ack_at;
  logic [15:0] rd;
  logic        eu;
  initial begin
    bus   = 6'h3E;
    wdata = 16'h0000;
  end
  // Cycle counts are 8 MHz master timing seen in 8 ns steps
  task automatic run(input logic wr, input logic en, input logic dm);
    int i;
    bus    <= {1'b0, 3'b111, ~wr, dm};
    wdata  <= 16'hA5C3;
    ack_at = 100;
    for (i = 1; i < 100; i++) begin
      @(posedge clk_sys);
      if (ack_b === 1'b0 && ack_at == 100) ack_at = i;
      // Late sampling, read data is only due 303 ns after the strobe
      if (i >= 38 && ack_at < 100) break;
      if (i == 16) bus.upper_byte_strobe_b <= ~wr;
      if (i == 16) bus.lower_byte_strobe_b <= ~wr;
      if (i == 23) bus.early_ack_enable_b <= ~en;
    end
    rd  = data_oe_b ? 16'hXXXX : data_in;
    eu  = early_in;
    bus <= 6'h3E;
    repeat (4) @(posedge clk_sys);
    wdata <= ~wdata;
  endtask
endmodule

//--- verif/tb_eas_slave.sv
// Self-checking bench for the early-acknowledge bus slave
module tb_eas_slave;
  import eas_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, rst_b = 0, sel = 0, mem = 1, rf = 0, mem_done = 0, wr_seen = 0;
  logic        mem_req, mem_wr, oe_b, ack_out, ack_oe_b, early_used;
  logic [15:0] mem_rdata = 16'h0000, dout;
  wire  [15:0] wdata;
  eas_bus_in_t bus;
  wire         ack_b = ack_oe_b ? 1'b1 : ack_out;
  int          num_errors = 0, checked = 0;
  always #4 clk_sys = ~clk_sys;
  eas_slave dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1), .bus_in(bus),
    .bus_data_in(wdata), .bus_data_out(dout), .bus_data_oe_b(oe_b),
    .transfer_acknowledge_b_out(ack_out), .transfer_acknowledge_oe_b(ack_oe_b),
    .card_select(sel), .card_is_memory(mem), .refresh_busy(rf), .mem_req(mem_req),
    .mem_wr(mem_wr), .mem_done(mem_done), .mem_rdata(mem_rdata), .early_used(early_used));
  eas_master m (.clk_sys(clk_sys), .ack_b(ack_b), .data_oe_b(oe_b), .data_in(dout),
    .early_in(early_used),
    .bus(bus), .wdata(wdata));
  // Card memory is slow on purpose so early and normal answers differ
  always @(posedge clk_sys) if (mem_req === 1'b1) begin
    wr_seen <= mem_wr;
    repeat (30) @(posedge clk_sys);
    mem_done  <= 1'b1;
    mem_rdata <= 16'h5A3C;
    @(posedge clk_sys);
    mem_done  <= 1'b0;
    mem_rdata <= 16'hA5C3;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Early answer lands two steps after the enable, normal one after memory
  task automatic cyc(input logic wr, en, dm, s, mm, r, early);
    @(posedge clk_sys);
    sel <= s;
    mem <= mm;
    rf  <= r;
    m.run(wr, en, dm);
    check(early ? m.ack_at <= 26 : m.ack_at > 26 && m.ack_at <= 40, 16'h1);
    check({15'h0000, m.eu}, {15'h0000, early});
    check(ack_b, 16'h1);
    if (!wr) check(m.rd, 16'h5A3C);
  endtask
  task automatic t_early_read;  cyc(0, 1, 0, 1, 1, 0, 1); endtask
  task automatic t_no_enable;   cyc(0, 0, 0, 1, 1, 0, 0); endtask
  task automatic t_refresh;     cyc(0, 1, 0, 1, 1, 1, 0); endtask
  task automatic t_io_dma;      cyc(0, 1, 1, 1, 0, 0, 0); endtask
  task automatic t_mem_dma;     cyc(0, 1, 1, 1, 1, 0, 1); endtask
  task automatic t_write;
    cyc(1, 1, 0, 1, 1, 0, 1);
    check(wr_seen, 16'h1);
  endtask
  task automatic t_unselected;
    @(posedge clk_sys);
    sel <= 1'b0;
    m.run(0, 1, 0);
    check(16'(m.ack_at), 16'h0064);
  endtask
  task automatic stop_test;
    $display("Errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_early_read;
    t_no_enable;
    t_refresh;
    t_io_dma;
    t_mem_dma;
    t_write;
    t_unselected;
    stop_test;
  end
  initial begin
    #20000;
    num_errors++;
    stop_test;
  end
endmodule
